// file: rtl/saci_defs.svh
`ifndef SACI_DEFS_SVH
`define SACI_DEFS_SVH

// core clock rate and analog timing
`define SACI_CLK_HZ 10000000
`define SACI_T_PWRUP_US 700
`define SACI_PWRUP_CYC ((64'(`SACI_T_PWRUP_US) * 64'(`SACI_CLK_HZ)) / 64'(1000000))
`define SACI_CAL_CYC 4944
`define SACI_AZ_CYC 76
`define SACI_CONV12_CYC 6'h2C
`define SACI_CONV8_CYC 6'h15
`define SACI_ACQ6_CYC 6'h06
`define SACI_ACQ10_CYC 6'h0A
`define SACI_ACQ18_CYC 6'h12
`define SACI_ACQ34_CYC 6'h22

// serial framing
`define SACI_INSTR_LEN 5'h08
`define SACI_WORD_W 17
`define SACI_LEN_W 5
`define SACI_RST_LEN 5'h0D

// mode codes, first nibble bit is the fifth bit shifted in
`define SACI_M_FS 4'h3
`define SACI_M_OFS 4'h7
`define SACI_M_CAL 4'h8
`define SACI_M_AZ 4'h9
`define SACI_M_PUP 4'hA
`define SACI_M_PDN 4'hB
`define SACI_M_STAT 4'hC
`define SACI_M_SIGN 4'hD
`define SACI_M_ACQ 4'hE
`define SACI_M_USER 4'hF

// output word length codes
`define SACI_WL_8 2'h0
`define SACI_WL_12 2'h1
`define SACI_WL_16 2'h2

// reset values
`define SACI_RST_ACQ 2'h1
`define SACI_RST_WLEN 2'h1
`define SACI_RST_SIGN 1'b1
`define SACI_RST_MSBF 1'b1
`define SACI_RST_TEST 1'b0

// substitute result codes
`define SACI_ERR_CODE 13'h1555
`define SACI_FS_CODE 13'h0FFF
`define SACI_OFS_CODE 13'h0000

// status bit positions
`define SACI_ST_PU 0
`define SACI_ST_PD 1
`define SACI_ST_CAL 2
`define SACI_ST_W8 3
`define SACI_ST_W12 4
`define SACI_ST_W16 5
`define SACI_ST_SIGN 6
`define SACI_ST_MSBF 7
`define SACI_ST_TEST 8

`endif

// file: rtl/saci_pkg.sv
`include "saci_defs.svh"

package saci_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACQ,
    ST_PROGRAM_ENABLE_PIN,
    ST_CAL,
    ST_AZ,
    ST_PWRUP,
    ST_DOWN
  } saci_state_t;

  typedef struct packed {
    logic [1:0] acq_sel;
    logic [1:0] wlen;
    logic sign_on;
    logic msb_first;
    logic test_mode;
  } saci_cfg_t;

  typedef struct packed {
    logic [`SACI_WORD_W-1:0] bits;
    logic [`SACI_LEN_W-1:0] len;
  } saci_word_t;

endpackage

// file: rtl/saci_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module saci_sync2 (
  input wire logic clk,
  input wire logic d,
  output logic sync_q
);

  logic meta_q;

  // meta_q is read by the second stage only
  always_ff @(posedge clk) begin
    meta_q <= d;
    sync_q <= meta_q;
  end

endmodule

`default_nettype wire

// file: rtl/saci_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "saci_defs.svh"

module saci_seq #(
  parameter int unsigned CAL_CYC = `SACI_CAL_CYC,
  parameter int unsigned PWRUP_CYC = 32'(`SACI_PWRUP_CYC),
  parameter int unsigned AZ_CYC = `SACI_AZ_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go_program_enable_pin,
  input wire logic go_cal,
  input wire logic go_az,
  input wire logic go_pwrup,
  input wire logic go_pwrdn,
  input wire logic abort,
  input wire logic pd,
  input wire logic [5:0] acq_cyc,
  input wire logic [5:0] program_enable_pin_cyc,
  output saci_pkg::saci_state_t state_q,
  output logic eoc_q,
  output logic done_q,
  output logic corrupt_q
);

  saci_pkg::saci_state_t state_d;
  logic [12:0] cnt_q;
  logic [12:0] cnt_d;
  logic swdn_q;
  logic swdn_d;

  wire cnt_end = (cnt_q == 13'h0000);
  wire in_program_enable_pin = (state_q == saci_pkg::ST_ACQ) || (state_q == saci_pkg::ST_PROGRAM_ENABLE_PIN);

  // every interval is timed in core clock cycles, never serial clock ones
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_end ? cnt_q : cnt_q - 13'h0001;
    swdn_d = go_pwrup ? 1'b0 : (go_pwrdn ? 1'b1 : swdn_q);
    case (state_q)
      saci_pkg::ST_IDLE: begin
        if (go_cal) begin
          state_d = saci_pkg::ST_CAL;
          cnt_d = 13'(CAL_CYC - 1);
        end else if (go_az) begin
          state_d = saci_pkg::ST_AZ;
          cnt_d = 13'(AZ_CYC - 1);
        end else if (go_program_enable_pin) begin
          state_d = saci_pkg::ST_ACQ;
          cnt_d = 13'(acq_cyc) - 13'h0001;
        end
      end
      saci_pkg::ST_ACQ: begin
        if (cnt_end) begin
          state_d = saci_pkg::ST_PROGRAM_ENABLE_PIN;
          cnt_d = 13'(program_enable_pin_cyc) - 13'h0001;
        end
      end
      saci_pkg::ST_PROGRAM_ENABLE_PIN, saci_pkg::ST_CAL, saci_pkg::ST_AZ, saci_pkg::ST_PWRUP: begin
        if (cnt_end) begin
          state_d = saci_pkg::ST_IDLE;
        end
      end
      saci_pkg::ST_DOWN: begin
        if (!pd && !swdn_d) begin
          state_d = saci_pkg::ST_PWRUP;
          cnt_d = 13'(PWRUP_CYC - 1);
        end
      end
      default: state_d = saci_pkg::ST_IDLE;
    endcase
    // a select fall cuts the running conversion; a start that arrives in the
    // same cycle begins the new one at once instead of being lost
    if (abort && in_program_enable_pin) begin
      state_d = saci_pkg::ST_IDLE;
      if (go_program_enable_pin) begin
        state_d = saci_pkg::ST_ACQ;
        cnt_d = 13'(acq_cyc) - 13'h0001;
      end
    end
    if ((pd || swdn_d) && state_q != saci_pkg::ST_DOWN) begin
      state_d = saci_pkg::ST_DOWN;
    end
  end

  // busy flag low for any cycle that is not idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= saci_pkg::ST_IDLE;
      cnt_q <= 13'h0000;
      swdn_q <= 1'b0;
      eoc_q <= 1'b1;
      done_q <= 1'b0;
      corrupt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      swdn_q <= swdn_d;
      eoc_q <= (state_d == saci_pkg::ST_IDLE);
      done_q <= (state_q == saci_pkg::ST_PROGRAM_ENABLE_PIN) && (state_d == saci_pkg::ST_IDLE) && cnt_end;
      corrupt_q <= in_program_enable_pin && (state_d == saci_pkg::ST_DOWN);
    end
  end

endmodule

`default_nettype wire

// file: rtl/saci_ctrl.sv
// Overview of operation
// - rising serial clock shifts instruction bit in
// - falling serial clock presents next result bit
// - continuous select: first bit at conversion done; here it shows only at the next frame wrap
// - toggled select: first bit at select fall
// - output driven while selected, else released
// - result and status words shifted out
// - done flag low during busy cycles
// - select fall aborts and restarts conversion
// - frame length equals programmed word length
// - ready flag low while shifting, high after
// - program enable high: read-only, no changes
// - power pin controls power, up within 700us
// - power-down anytime corrupts running conversion
// - acquisition lasts 6, 10, 18 or 34 cycles
// - conversion timing from conversion clock only
// - defined configuration after reset
// - acquisition and sign instruction starts nothing
`timescale 1ns/1ps
`default_nettype none
`include "saci_defs.svh"

module saci_ctrl #(
  parameter int unsigned CAL_CYC = `SACI_CAL_CYC,
  parameter int unsigned PWRUP_CYC = 32'(`SACI_PWRUP_CYC)
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic SERIAL_CLK,
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_INSTRUCTION_INPUT,
  input wire logic PROGRAM_ENABLE_PIN_N,
  input wire logic POWER_DOWN_PIN,
  input wire logic [12:0] SAMPLE_CODE,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OE,
  output logic OUTPUT_READY_FLAG,
  output logic END_OF_CONVERSION,
  output logic [3:0] INPUT_SELECTOR
);

  // number of bits in a frame for a given format
  function automatic logic [4:0] word_len(input saci_pkg::saci_cfg_t c);
    logic [4:0] n;
    case (c.wlen)
      `SACI_WL_8: n = 5'h08;
      `SACI_WL_12: n = 5'h0C;
      default: n = 5'h10;
    endcase
    return n + {4'h0, c.sign_on};
  endfunction

  // acquisition length in conversion clock cycles
  function automatic logic [5:0] acq_cycles(input logic [1:0] sel);
    logic [5:0] n;
    case (sel)
      2'h0: n = `SACI_ACQ6_CYC;
      2'h1: n = `SACI_ACQ10_CYC;
      2'h2: n = `SACI_ACQ18_CYC;
      default: n = `SACI_ACQ34_CYC;
    endcase
    return n;
  endfunction

  // lays a result out left-aligned, first bit to go at bit 16
  function automatic saci_pkg::saci_word_t build_word(input logic [12:0] d,
      input saci_pkg::saci_cfg_t c);
    logic [16:0] pay;
    saci_pkg::saci_word_t w;
    w.len = word_len(c);
    w.bits = 17'h00000;
    case (c.wlen)
      `SACI_WL_8: pay = {8'h00, d[12], d[11:4]};
      `SACI_WL_12: pay = {4'h0, d};
      default: pay = c.sign_on ? {{4{d[12]}}, d} : {5'h00, d[11:0]};
    endcase
    if (!c.sign_on) begin
      pay[w.len] = 1'b0;
    end
    for (int i = 0; i < 17; i++) begin
      if (i < int'(w.len)) begin
        w.bits[16 - i] = c.msb_first ? pay[int'(w.len) - 1 - i] : pay[i];
      end
    end
    return w;
  endfunction

  // status goes out bit 0 first, cut to the current word length
  function automatic saci_pkg::saci_word_t build_status(input logic [8:0] st,
      input saci_pkg::saci_cfg_t c);
    saci_pkg::saci_word_t w;
    w.len = word_len(c);
    w.bits = 17'h00000;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(w.len)) begin
        w.bits[16 - i] = st[i];
      end
    end
    return w;
  endfunction

  // ---- link side state (serial clock) ----
  // everything here runs on the host's clock; the core sees it only through
  // toggles and held words, never as raw multi-bit values
  logic lrst_n;
  logic cs_prev_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] isr_q;
  logic [7:0] instr_hold_q;
  logic instr_tog_q;
  logic abort_tog_q;
  logic prog_bad_q;
  logic ack_s;
  logic txt_s;
  logic tx_seen_q;
  logic [16:0] sh_q;
  logic [4:0] len_q;
  saci_pkg::saci_word_t word_q;

  // ---- core side state (conversion clock) ----
  // the sequencer and configuration live here so that every analog interval
  // is counted on the conversion clock whatever the host's clock does
  logic pd_s;
  logic instr_tog_s;
  logic abort_tog_s;
  logic instr_seen_q;
  logic abort_seen_q;
  logic tx_tog_q;
  logic [1:0] src_q;
  saci_pkg::saci_cfg_t cfg_q;
  saci_pkg::saci_cfg_t cfg_d;
  saci_pkg::saci_word_t txw_q;
  saci_pkg::saci_state_t seq_state;
  logic seq_done;
  logic seq_corrupt;
  logic [8:0] st;

  // crossings: levels and toggles through two flops each
  // toggles are used instead of pulses because either clock may be the
  // faster one; a pulse could be missed, a toggle cannot
  // limitation: a second instruction is refused until the first is seen
  // back from the core, so instructions closer than that are dropped
  saci_sync2 u_lrst_sync (.clk(SERIAL_CLK), .d(RESET_N), .sync_q(lrst_n));
  saci_sync2 u_ack_sync (.clk(SERIAL_CLK), .d(instr_seen_q), .sync_q(ack_s));
  saci_sync2 u_tx_sync (.clk(SERIAL_CLK), .d(tx_tog_q), .sync_q(txt_s));
  saci_sync2 u_pd_sync (.clk(CORE_CLK), .d(POWER_DOWN_PIN), .sync_q(pd_s));
  saci_sync2 u_it_sync (.clk(CORE_CLK), .d(instr_tog_q), .sync_q(instr_tog_s));
  saci_sync2 u_ab_sync (.clk(CORE_CLK), .d(abort_tog_q), .sync_q(abort_tog_s));

  // link framing decode; select and program enable are launched by the host on
  // this clock, so they are used without synchronisers
  wire cs_low = !CHIP_SELECT_N;
  wire frame_wrap = (bit_cnt_q == len_q);
  wire frame_start = cs_low && ((bit_cnt_q == 5'h00) || frame_wrap);
  wire [4:0] cnt_nxt = frame_wrap ? 5'h01 : bit_cnt_q + 5'h01;
  wire [7:0] isr_nxt = {SERIAL_INSTRUCTION_INPUT, isr_q[7:1]};
  wire prog_bad_d = PROGRAM_ENABLE_PIN_N || (!frame_start && prog_bad_q);
  wire instr_free = (instr_tog_q == ack_s);
  wire instr_done = cs_low && (cnt_nxt == `SACI_INSTR_LEN) && !prog_bad_d && instr_free;
  wire cs_fall = cs_low && !cs_prev_q && !PROGRAM_ENABLE_PIN_N;
  wire shifting = (bit_cnt_q != 5'h00) && (bit_cnt_q < len_q);
  wire tx_new = (txt_s != tx_seen_q);
  wire [16:0] sh_d = shifting ? {sh_q[15:0], 1'b0} : word_q.bits;

  // rising edge: instruction capture and frame count
  always_ff @(posedge SERIAL_CLK) begin
    if (!lrst_n) begin
      cs_prev_q <= 1'b0;
      bit_cnt_q <= 5'h00;
      isr_q <= 8'h00;
      instr_hold_q <= 8'h00;
      instr_tog_q <= 1'b0;
      abort_tog_q <= 1'b0;
      prog_bad_q <= 1'b0;
      SERIAL_DATA_OE <= 1'b0;
    end else begin
      cs_prev_q <= cs_low;
      SERIAL_DATA_OE <= cs_low;
      bit_cnt_q <= cs_low ? cnt_nxt : 5'h00;
      prog_bad_q <= prog_bad_d;
      if (cs_low) begin
        isr_q <= isr_nxt;
      end
      if (instr_done) begin
        instr_hold_q <= isr_nxt;
        instr_tog_q <= !instr_tog_q;
      end
      if (cs_fall) begin
        abort_tog_q <= !abort_tog_q;
      end
    end
  end

  // falling edge: output shifting; the head is preloaded so that the first bit
  // is already on the pin when select falls or when the frame wraps
  always_ff @(negedge SERIAL_CLK) begin
    if (!lrst_n) begin
      sh_q <= 17'h00000;
      SERIAL_DATA_OUT <= 1'b0;
      word_q <= '{bits: 17'h00000, len: `SACI_RST_LEN};
      len_q <= `SACI_RST_LEN;
      tx_seen_q <= 1'b0;
      OUTPUT_READY_FLAG <= 1'b1;
    end else begin
      if (tx_new) begin
        word_q <= txw_q;
        tx_seen_q <= txt_s;
      end
      sh_q <= sh_d;
      SERIAL_DATA_OUT <= sh_d[16];
      if (!shifting) begin
        len_q <= word_q.len;
      end
      OUTPUT_READY_FLAG <= !shifting;
    end
  end

  // core decode of a completed instruction; the held byte is stable until
  // acknowledged, so reading it after the toggle arrives is safe
  wire instr_new = (instr_tog_s != instr_seen_q);
  wire abort_new = (abort_tog_s != abort_seen_q);
  wire [3:0] mode = {instr_hold_q[4], instr_hold_q[5], instr_hold_q[6], instr_hold_q[7]};
  wire is_mode_cmd = instr_new && mode[3];
  wire program_enable_pin_busy = (seq_state == saci_pkg::ST_ACQ) || (seq_state == saci_pkg::ST_PROGRAM_ENABLE_PIN);
  // the abort toggle and the instruction toggle leave the link a few link
  // cycles apart and may land on the same core edge; the start must then be
  // taken, or the frame that cut the old conversion would start nothing
  wire program_enable_pin_ok = instr_new && !mode[3] &&
                 ((seq_state == saci_pkg::ST_IDLE) || (abort_new && program_enable_pin_busy));
  wire [1:0] fmt_wlen = (mode[1:0] == 2'h1) ? `SACI_WL_16 :
                        (mode[1:0] == 2'h2) ? `SACI_WL_8 : `SACI_WL_12;
  wire go_cal = is_mode_cmd && (mode == `SACI_M_CAL);
  wire go_az = is_mode_cmd && (mode == `SACI_M_AZ);
  wire go_pup = is_mode_cmd && (mode == `SACI_M_PUP);
  wire go_pdn = is_mode_cmd && (mode == `SACI_M_PDN);
  wire go_stat = is_mode_cmd && (mode == `SACI_M_STAT);
  wire [1:0] src_d = !program_enable_pin_ok ? src_q : (mode == `SACI_M_FS) ? 2'h1 :
                     (mode == `SACI_M_OFS) ? 2'h2 : 2'h0;
  wire [12:0] code = (src_q == 2'h1) ? `SACI_FS_CODE :
                     (src_q == 2'h2) ? `SACI_OFS_CODE : SAMPLE_CODE;
  wire [5:0] program_enable_pin_cyc = (cfg_q.wlen == `SACI_WL_8) ? `SACI_CONV8_CYC : `SACI_CONV12_CYC;
  wire tx_load = seq_done || seq_corrupt || go_stat;

  // configuration updates; format changes apply to the next word out
  always_comb begin
    cfg_d = cfg_q;
    if (program_enable_pin_ok) begin
      cfg_d.wlen = fmt_wlen;
      cfg_d.msb_first = !mode[2];
    end
    if (is_mode_cmd && mode == `SACI_M_SIGN) begin
      cfg_d.sign_on = instr_hold_q[0];
    end
    if (is_mode_cmd && mode == `SACI_M_ACQ) begin
      cfg_d.acq_sel = {instr_hold_q[0], instr_hold_q[1]};
    end
    if (is_mode_cmd && mode == `SACI_M_USER) begin
      cfg_d.test_mode = instr_hold_q[0];
    end
  end

  // status word as seen by a status read
  always_comb begin
    st = 9'h000;
    st[`SACI_ST_PU] = (seq_state == saci_pkg::ST_PWRUP);
    st[`SACI_ST_PD] = (seq_state == saci_pkg::ST_DOWN);
    st[`SACI_ST_CAL] = (seq_state == saci_pkg::ST_CAL);
    st[`SACI_ST_W8] = (cfg_q.wlen == `SACI_WL_8);
    st[`SACI_ST_W12] = (cfg_q.wlen == `SACI_WL_12);
    st[`SACI_ST_W16] = (cfg_q.wlen == `SACI_WL_16);
    st[`SACI_ST_SIGN] = cfg_q.sign_on;
    st[`SACI_ST_MSBF] = cfg_q.msb_first;
    st[`SACI_ST_TEST] = cfg_q.test_mode;
  end

  // a status read captures the flags of the cycle in which it is decoded;
  // a later change only shows on the next status read
  // core registers; the next word crosses as a toggle, its data held stable
  // for many link cycles because loads are at least a core cycle apart
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      instr_seen_q <= 1'b0;
      abort_seen_q <= 1'b0;
      tx_tog_q <= 1'b0;
      src_q <= 2'h0;
      INPUT_SELECTOR <= 4'h0;
      cfg_q <= '{acq_sel: `SACI_RST_ACQ, wlen: `SACI_RST_WLEN, sign_on: `SACI_RST_SIGN,
                 msb_first: `SACI_RST_MSBF, test_mode: `SACI_RST_TEST};
      txw_q <= '{bits: 17'h00000, len: `SACI_RST_LEN};
    end else begin
      instr_seen_q <= instr_tog_s;
      abort_seen_q <= abort_tog_s;
      cfg_q <= cfg_d;
      src_q <= src_d;
      if (program_enable_pin_ok) begin
        INPUT_SELECTOR <= instr_hold_q[3:0];
      end
      if (seq_done) begin
        txw_q <= build_word(code, cfg_q);
      end else if (seq_corrupt) begin
        txw_q <= build_word(`SACI_ERR_CODE, cfg_q);
      end else if (go_stat) begin
        txw_q <= build_status(st, cfg_q);
      end
      if (tx_load) begin
        tx_tog_q <= !tx_tog_q;
      end
    end
  end

  // sequencer: busy flag, interval counting and power state
  // the auto-zero length keeps its default, only calibration and power-up
  // are shortened for simulation through the top parameters
  saci_seq #(
    .CAL_CYC(CAL_CYC),
    .PWRUP_CYC(PWRUP_CYC)
  ) u_seq (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .go_program_enable_pin(program_enable_pin_ok),
    .go_cal(go_cal),
    .go_az(go_az),
    .go_pwrup(go_pup),
    .go_pwrdn(go_pdn),
    .abort(abort_new),
    .pd(pd_s),
    .acq_cyc(acq_cycles(cfg_q.acq_sel)),
    .program_enable_pin_cyc(program_enable_pin_cyc),
    .state_q(seq_state),
    .eoc_q(END_OF_CONVERSION),
    .done_q(seq_done),
    .corrupt_q(seq_corrupt)
  );

endmodule

`default_nettype wire

// file: tb/saci_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none

module saci_ctrl_checker #(
  parameter int unsigned CAL_CYC = 4944,
  parameter int unsigned PWRUP_CYC = 7000
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic SERIAL_CLK,
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_INSTRUCTION_INPUT,
  input wire logic PROGRAM_ENABLE_PIN_N,
  input wire logic POWER_DOWN_PIN,
  input wire logic [12:0] SAMPLE_CODE,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_OE,
  input wire logic OUTPUT_READY_FLAG,
  input wire logic END_OF_CONVERSION,
  input wire logic [3:0] INPUT_SELECTOR
);
  localparam int BUSY_MAX = PWRUP_CYC + CAL_CYC + 90;
  logic [15:0] busy_q;

  // busy span; the pin is excluded since it may hold the part down forever
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || END_OF_CONVERSION || POWER_DOWN_PIN)
      busy_q <= 16'h0000;
    else
      busy_q <= busy_q + 16'h0001;
  end

  // link side: drive and ready flag follow the frame
  a_oe_on_select: assert property (
    @(posedge SERIAL_CLK) disable iff (!RESET_N) !CHIP_SELECT_N |=> SERIAL_DATA_OE)
    else $error("output released while selected");
  a_oe_off_select: assert property (
    @(posedge SERIAL_CLK) disable iff (!RESET_N) CHIP_SELECT_N |=> !SERIAL_DATA_OE)
    else $error("output driven while deselected");
  a_ready_low_sel: assert property (
    @(posedge SERIAL_CLK) disable iff (!RESET_N) $fell(OUTPUT_READY_FLAG) |-> SERIAL_DATA_OE)
    else $error("ready fell outside a frame");
  a_ready_rise_end: assert property (
    @(posedge SERIAL_CLK) disable iff (!RESET_N)
    $rose(OUTPUT_READY_FLAG) |-> $past(SERIAL_DATA_OE))
    else $error("ready rose without a shifted bit");

  // core side: busy flag against power and reset
  a_pd_busy: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N) POWER_DOWN_PIN [*5] |-> !END_OF_CONVERSION)
    else $error("busy flag high while powered down");
  a_pwrup_hold: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    $fell(POWER_DOWN_PIN) |=> (!END_OF_CONVERSION) [*8])
    else $error("power-up finished too early");
  a_busy_bounded: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N) int'(busy_q) <= BUSY_MAX)
    else $error("busy flag low for too long");
  a_reset_vals: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(RESET_N) |-> INPUT_SELECTOR == 4'h0 && END_OF_CONVERSION)
    else $error("wrong values after reset");
endmodule

bind saci_ctrl saci_ctrl_checker #(.CAL_CYC(CAL_CYC), .PWRUP_CYC(PWRUP_CYC)) u_chk (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .SERIAL_CLK(SERIAL_CLK),
  .CHIP_SELECT_N(CHIP_SELECT_N), .SERIAL_INSTRUCTION_INPUT(SERIAL_INSTRUCTION_INPUT),
  .PROGRAM_ENABLE_PIN_N(PROGRAM_ENABLE_PIN_N), .POWER_DOWN_PIN(POWER_DOWN_PIN),
  .SAMPLE_CODE(SAMPLE_CODE), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
  .SERIAL_DATA_OE(SERIAL_DATA_OE), .OUTPUT_READY_FLAG(OUTPUT_READY_FLAG),
  .END_OF_CONVERSION(END_OF_CONVERSION), .INPUT_SELECTOR(INPUT_SELECTOR));

`default_nettype wire

// file: tb/saci_host.sv
`timescale 1ns/1ps
`default_nettype none

module saci_host (
  output logic sclk,
  output logic cs_n,
  output logic di,
  output logic prog_n,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic line;

  // a released line shows the inverse, so a stale bit never passes as data
  assign line = sdo_oe ? sdo : ~sdo;

  // link clock runs free: the design sees select edges only on rising edges
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    di = 1'b0;
    prog_n = 1'b0;
    #1.7;
    forever #3 sclk = ~sclk;
  end

  // one select-toggled transfer of n bits; ro asks for a read-only frame
  task automatic frame(input logic [7:0] ins, input int n, input logic ro,
                       output logic [16:0] rx);
    int k;
    rx = 17'h00000;
    @(negedge sclk);
    prog_n = ro;
    @(negedge sclk);
    cs_n = 1'b0;
    di = ins[0];
    for (k = 1; k <= n; k++) begin
      @(posedge sclk);
      #1 rx[k-1] = line;
      @(negedge sclk);
      di = (k < 8) ? ins[k] : ~di;
    end
    cs_n = 1'b1;
  endtask
endmodule

`default_nettype wire

// file: tb/saci_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module saci_ctrl_tb;
  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] addr;
    logic [12:0] code;
    logic [12:0] want;
    logic [4:0] len;
    logic lsb;
  } saci_row_t;

  logic core_clk, reset_n, pd, sclk, cs_n, di, prog_n, sdo, sdo_oe, ready, eoc;
  logic [12:0] code;
  logic [3:0] sel;
  logic [16:0] rx;
  logic [16:0] acq_add [4] = '{17'h00000, 17'h00004, 17'h0000C, 17'h0001C};
  int failures, checks_done, n, cur_len;
  int busy [4];
  saci_row_t rows [6];

  saci_ctrl #(.CAL_CYC(20), .PWRUP_CYC(30)) DUT (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .SERIAL_CLK(sclk), .CHIP_SELECT_N(cs_n),
    .SERIAL_INSTRUCTION_INPUT(di), .PROGRAM_ENABLE_PIN_N(prog_n), .POWER_DOWN_PIN(pd),
    .SAMPLE_CODE(code), .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_OE(sdo_oe),
    .OUTPUT_READY_FLAG(ready), .END_OF_CONVERSION(eoc), .INPUT_SELECTOR(sel));

  saci_host host (.sclk(sclk), .cs_n(cs_n), .di(di), .prog_n(prog_n), .sdo(sdo),
    .sdo_oe(sdo_oe));

  // conversion clock, 100 ns
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // serial order of a word: index 0 is the first bit on the line
  function automatic logic [16:0] fmt(input logic [12:0] c, input int len, input logic lsb);
    logic [16:0] v, o;
    v = {{4{c[12]}}, c};
    o = 17'h00000;
    for (int i = 0; i < len; i++)
      o[i] = lsb ? v[i] : v[len-1-i];
    return o;
  endfunction

  function automatic logic [7:0] mk(input logic [3:0] m, input logic [3:0] a);
    return {m[0], m[1], m[2], m[3], a};
  endfunction

  // inputs set after a tick change 5 ns after the core edge
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #5;
  endtask

  task automatic wait_eoc(input logic lvl, input int lim);
    n = 0;
    while (eoc !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      failures++;
      $display("Error at %0t: busy flag stuck", $time);
    end
  endtask

  task automatic program_enable_pin(input logic [7:0] ins);
    host.frame(ins, cur_len, 1'b0, rx);
    wait_eoc(1'b0, 20);
    wait_eoc(1'b1, 300);
  endtask

  // read-only frame; the address bits sent are ignored
  task automatic rd(input int len);
    tick(3);
    host.frame(8'h0F, len, 1'b1, rx);
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // cut a hang short; the whole run needs well under 1 ms
  initial begin
    #2000000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    reset_n = 1'b0;
    pd = 1'b0;
    code = 13'h0000;
    failures = 0;
    checks_done = 0;
    cur_len = 13;
    rows[0] = '{4'h0, 4'h3, 13'h0A5C, 13'h0A5C, 5'h0D, 1'b0};
    rows[1] = '{4'h4, 4'h6, 13'h1234, 13'h1234, 5'h0D, 1'b1};
    rows[2] = '{4'h1, 4'h9, 13'h1F0E, 13'h1F0E, 5'h11, 1'b0};
    rows[3] = '{4'h5, 4'h2, 13'h0371, 13'h0371, 5'h11, 1'b1};
    rows[4] = '{4'h3, 4'h0, 13'h0123, 13'h0FFF, 5'h0D, 1'b0};
    rows[5] = '{4'h7, 4'h0, 13'h1ABC, 13'h0000, 5'h0D, 1'b1};
    tick(20);
    reset_n = 1'b1;
    tick(4);
    foreach (rows[i]) begin
      code = rows[i].code;
      program_enable_pin(mk(rows[i].mode, rows[i].addr));
      chk(17'(sel), 17'(rows[i].addr), "selector");
      cur_len = int'(rows[i].len);
      rd(cur_len);
      chk(rx, fmt(rows[i].want, cur_len, rows[i].lsb), "word");
      tick(8);
      chk(17'({eoc, ready, sel}), 17'({2'h3, rows[i].addr}), "read only");
    end
    $display("test formats done");
    for (int s = 0; s < 4; s++) begin
      host.frame(mk(4'hE, {2'h0, s[0], s[1]}), cur_len, 1'b0, rx);
      tick(8);
      chk(17'(eoc), 17'h00001, "acq starts nothing");
      program_enable_pin(mk(4'h0, 4'h1));
      busy[s] = n;
    end
    for (int s = 1; s < 4; s++)
      chk(17'(busy[s] - busy[0]), acq_add[s], "acq span");
    $display("test acquisition done");
    code = 13'h0777;
    host.frame(mk(4'h0, 4'h5), cur_len, 1'b0, rx);
    wait_eoc(1'b0, 20);
    tick(5);
    code = 13'h1111;
    host.frame(mk(4'h0, 4'h7), cur_len, 1'b0, rx);
    tick(6);
    wait_eoc(1'b1, 300);
    chk(17'(sel), 17'h00007, "abort restart");
    rd(cur_len);
    chk(rx, fmt(13'h1111, 13, 1'b0), "abort word");
    $display("test abort done");
    code = 13'h0ABC;
    host.frame(mk(4'h1, 4'h2), cur_len, 1'b0, rx);
    cur_len = 17;
    wait_eoc(1'b0, 20);
    tick(5);
    pd = 1'b1;
    tick(10);
    chk(17'(eoc), 17'h00000, "down busy");
    pd = 1'b0;
    wait_eoc(1'b1, 100);
    chk(17'(n >= 30 && n <= 40), 17'h00001, "power-up span");
    rd(17);
    chk(rx, fmt(13'h1555, 17, 1'b0), "corrupt word");
    rd(17);
    chk(rx, fmt(13'h1555, 17, 1'b0), "word repeats");
    $display("test power-down done");
    host.frame(mk(4'h0, 4'hC), 5, 1'b0, rx);
    tick(10);
    chk(17'({eoc, sel}), 17'h00012, "short frame");
    $display("test short frame done");
    program_enable_pin(mk(4'h8, 4'h0));
    chk(17'(n >= 15 && n <= 25), 17'h00001, "cal span");
    host.frame(mk(4'hC, 4'h0), cur_len, 1'b0, rx);
    rd(17);
    chk(rx, 17'h000E0, "status word");
    $display("test status done");
    reset_n = 1'b0;
    tick(20);
    chk(17'({sdo, sdo_oe, ready, eoc, sel}), 17'h00030, "in reset");
    reset_n = 1'b1;
    tick(4);
    rd(13);
    tick(1);
    chk(17'(ready), 17'h00001, "default length");
    $display("test reset done");
    finish_test();
  end
endmodule

`default_nettype wire
